// ===== core/card_mode_decode.v
`timescale 1ns/1ns
`include "ebi_steer_defines.vh"
module card_mode_decode (
    input wire [31:0] i_addr,
    input wire i_slot0_card_assign,
    input wire i_slot1_card_assign,
    input wire i_flash_region_assign,
    output wire o_slot0_hit,
    output wire o_slot1_hit,
    output wire o_flash_hit,
    output wire [1:0] o_mode_class
);
    function [1:0] mode_class;
        input [2:0] code;
        begin
            // unlisted codes follow A23 and A22 like their neighbours
            if (!code[2]) begin
                mode_class = `CLASS_MEM;
            end else if (!code[1]) begin
                mode_class = `CLASS_IO;
            end else if (code == `MODE_ALT_IDE) begin
                mode_class = `CLASS_ALT_IDE;
            end else begin
                mode_class = `CLASS_IDE;
            end
        end
    endfunction

    wire [3:0] region = i_addr[`REGION_MSB:`REGION_LSB];

    assign o_slot0_hit = i_slot0_card_assign && (region == `REGION_SLOT0); // RULE18
    assign o_slot1_hit = i_slot1_card_assign && (region == `REGION_SLOT1); // RULE18
    assign o_flash_hit = i_flash_region_assign && (region == `REGION_FLASH); // RULE7
    assign o_mode_class = mode_class(i_addr[`MODE_MSB:`MODE_LSB]); // RULE19
endmodule

// ===== core/ebi_steer_defines.vh
`ifndef EBI_STEER_DEFINES_VH
`define EBI_STEER_DEFINES_VH

// transfer address region nibbles, bits 31:28
`define REGION_MSB 31
`define REGION_LSB 28
`define REGION_FLASH 4'h4
`define REGION_SLOT0 4'h5
`define REGION_SLOT1 4'h6

// card mode field position in the transfer address
`define MODE_MSB 23
`define MODE_LSB 21
`define MODE_ATTR 3'h0
`define MODE_COMMON 3'h2
`define MODE_IO 3'h4
`define MODE_IDE 3'h6
`define MODE_ALT_IDE 3'h7

// card mode classes
`define CLASS_MEM 2'h0
`define CLASS_IO 2'h1
`define CLASS_IDE 2'h2
`define CLASS_ALT_IDE 2'h3

// flash latch enable address bits
`define FLASH_ALE_BIT 21
`define FLASH_CLE_BIT 22

// card direction pin shares this address bit
`define RNW_ADDR_BIT 25

// static controller mode after reset
`define RST_BYTE_SELECT 1'h1
`define RST_BUS_WIDTH16 1'h1
`define RST_CS_CONTROLLED 1'h1
`define RST_MODE_Q 3'h0
`define RST_WAIT_CNT 8'h00

`endif

// ===== core/ext_bus_card_nand_steering.v
// Notes on behaviour
// RULE1: slot assign bits swap chip selects to card selects
// RULE2: assigned card select pins serve no other device
// RULE3: card accesses put card strobes on shared pins
// RULE4: card select 0 mirrors chip select 4 timing
// RULE5: direction valid with address whole transfer
// RULE6: card wait feeds controller wait, extends access
// RULE7: flash logic serves 0x4000_0000 to 0x4FFF_FFFF
// RULE8: chip select 3 routes strobes to flash
// RULE9: flash strobes drop when address leaves region
// RULE10: address latch on A21, command on A22
// RULE11: flash chip enable held by gp output
// RULE12: host polls flash ready/busy on gp input
// RULE13: A23 picks card io or memory mode
// RULE14: A21 picks alternate or plain ide mode
// RULE15: reset mode byte select, 16-bit, cs controlled
// RULE16: card reset, irq, detect on gp pins
// RULE17: sdram needs cs1 assign, upper data pins
// RULE18: slots at 0x5xxx_xxxx and 0x6xxx_xxxx
// RULE19: A[23:21] selects card access mode
// RULE20: io/ide use io strobes, memory uses oe/we
// RULE21: pin selection is purely combinational
`timescale 1ns/1ns
`include "ebi_steer_defines.vh"
module ext_bus_card_nand_steering (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_slot0_card_assign,
    input wire i_slot1_card_assign,
    input wire i_flash_region_assign,
    input wire i_sdram_region_assign,
    input wire [31:0] i_transfer_addr,
    input wire [25:0] i_smc_addr,
    input wire i_smc_rnw,
    input wire i_chip_select_3_n,
    input wire i_chip_select_4_n,
    input wire i_chip_select_5_n,
    input wire i_read_strobe_n,
    input wire i_write0_strobe_n,
    input wire i_write1_byte1_strobe_n,
    input wire i_write3_byte3_strobe_n,
    input wire i_byte0_select_n,
    input wire i_card0_bus16,
    input wire i_card1_bus16,
    input wire i_card_wait_pin_n,
    input wire i_mode_load,
    input wire i_mode_byte_select,
    input wire i_mode_bus16,
    input wire i_mode_cs_controlled,
    output reg o_external_wait_in_n,
    output reg o_chip_select_4_pin_n,
    output reg o_chip_select_5_pin_n,
    output reg o_read_pin_n,
    output reg o_write0_pin_n,
    output reg o_write1_pin_n,
    output reg o_write3_pin_n,
    output reg [25:0] o_addr_pin,
    output reg o_card_enable_low_n,
    output reg o_card_enable_high_n,
    output reg o_flash_output_enable_n,
    output reg o_flash_write_enable_n,
    output reg o_flash_ale,
    output reg o_flash_cle,
    output wire o_sdram_cs1_routed,
    output reg o_smc_byte_select_q,
    output reg o_smc_bus16_q,
    output reg o_smc_cs_controlled_q,
    output reg [2:0] o_card_mode_q,
    output reg o_card_busy_q,
    output reg [7:0] o_wait_cycles_q
);
    wire slot0_hit;
    wire slot1_hit;
    wire flash_hit;
    wire [1:0] mode_class;
    wire card_wait_n;
    wire card_hit;
    wire card_cs_n;
    wire card_bus16;
    reg card_oe_n;
    reg card_we_n;
    reg card_ior_n;
    reg card_iow_n;
    wire card_select_0_n;
    wire card_select_1_n;
    wire flash_sel;

    card_mode_decode u_decode (
        .i_addr(i_transfer_addr),
        .i_slot0_card_assign(i_slot0_card_assign),
        .i_slot1_card_assign(i_slot1_card_assign),
        .i_flash_region_assign(i_flash_region_assign),
        .o_slot0_hit(slot0_hit),
        .o_slot1_hit(slot1_hit),
        .o_flash_hit(flash_hit),
        .o_mode_class(mode_class)
    );

    // wait pin is asynchronous to the bus clock; idle level is high
    pin_sync_filter #(
        .RESET_LEVEL(1'b1)
    ) u_wait_sync (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_pin(i_card_wait_pin_n),
        .o_level_q(card_wait_n)
    );

    assign card_hit = slot0_hit || slot1_hit;
    // the card select is the controller's own chip select, no added delay
    assign card_cs_n = slot0_hit ? i_chip_select_4_n : i_chip_select_5_n; // RULE4
    assign card_bus16 = slot0_hit ? i_card0_bus16 : i_card1_bus16;
    // card selects are the controller's own selects, so timing is identical
    assign card_select_0_n = i_chip_select_4_n; // RULE4
    assign card_select_1_n = i_chip_select_5_n;
    // the region check keeps a stray chip select 3 off the flash
    assign flash_sel = flash_hit && !i_chip_select_3_n; // RULE8 RULE9

    // a card access counts only while its own chip select is low
    function card_selected;
        input hit;
        input cs_n;
        begin
            card_selected = hit && !cs_n;
        end
    endfunction

    // saturate rather than wrap, so long waits still read as long
    function [7:0] sat_inc;
        input [7:0] cnt;
        begin
            if (cnt == 8'hFF) begin
                sat_inc = cnt;
            end else begin
                sat_inc = cnt + 8'h01;
            end
        end
    endfunction

    // sdram routing is owned elsewhere, only reflected here
    assign o_sdram_cs1_routed = i_sdram_region_assign; // RULE17

    // synchronised wait goes straight to the controller; one filter delay
    // of latency must be covered by the card's wait assertion time
    always @* begin
        o_external_wait_in_n = card_wait_n; // RULE6
    end

    // dedicated select pins; no registers so no glitch at switch-over
    always @* begin
        if (i_slot0_card_assign) begin
            o_chip_select_4_pin_n = card_select_0_n; // RULE1 RULE4 RULE21
        end else begin
            o_chip_select_4_pin_n = i_chip_select_4_n;
        end
        if (i_slot1_card_assign) begin
            o_chip_select_5_pin_n = card_select_1_n; // RULE1 RULE21
        end else begin
            o_chip_select_5_pin_n = i_chip_select_5_n;
        end
    end

    // card strobe steering per mode class
    function [3:0] steer_card;
        input [1:0] cls;
        input rd_n;
        input wr_n;
        begin
            // bit order: output enable, write enable, io read, io write
            steer_card = 4'hF;
            case (cls)
                `CLASS_MEM: begin
                    steer_card[3] = rd_n; // RULE20
                    steer_card[2] = wr_n; // RULE20
                end
                `CLASS_IO: begin
                    steer_card[1] = rd_n; // RULE20 RULE13
                    steer_card[0] = wr_n; // RULE20
                end
                default: begin
                    // true ide holds output enable low for the whole access
                    steer_card[3] = 1'b0; // RULE14
                    steer_card[1] = rd_n; // RULE20
                    steer_card[0] = wr_n; // RULE20
                end
            endcase
        end
    endfunction

    // shared pins pick these up only during a card hit
    always @* begin
        {card_oe_n, card_we_n, card_ior_n, card_iow_n} =
            steer_card(mode_class, i_read_strobe_n, i_write0_strobe_n);
    end

    // shared pins follow the current transfer address
    always @* begin
        if (card_hit) begin
            o_read_pin_n = card_oe_n; // RULE3 RULE21
            o_write0_pin_n = card_we_n; // RULE3
            o_write1_pin_n = card_ior_n; // RULE3
            o_write3_pin_n = card_iow_n; // RULE3
            o_addr_pin = {i_smc_rnw, i_smc_addr[`RNW_ADDR_BIT-1:0]}; // RULE3 RULE5
        end else begin
            o_read_pin_n = i_read_strobe_n;
            o_write0_pin_n = i_write0_strobe_n;
            o_write1_pin_n = i_write1_byte1_strobe_n;
            o_write3_pin_n = i_write3_byte3_strobe_n;
            o_addr_pin = i_smc_addr;
        end
    end

    // card enables: both high when the space is not a card access
    function [1:0] card_enables;
        input sel;
        input [1:0] cls;
        input bus16;
        input bs0_n;
        input bs1_n;
        begin
            // bit order: low enable, high enable
            card_enables = 2'h3;
            if (sel) begin
                case (cls)
                    `CLASS_ALT_IDE: begin
                        card_enables = 2'h2;
                    end
                    `CLASS_IDE: begin
                        card_enables = 2'h1;
                    end
                    default: begin
                        // in memory and io modes an 8-bit slot uses only the low enable
                        if (bus16) begin
                            card_enables = {bs0_n, bs1_n};
                        end else begin
                            card_enables = 2'h1;
                        end
                    end
                endcase
            end
        end
    endfunction

    always @* begin
        {o_card_enable_low_n, o_card_enable_high_n} = card_enables(
            card_selected(card_hit, card_cs_n), mode_class, card_bus16,
            i_byte0_select_n, i_write1_byte1_strobe_n);
    end

    // flash strobes gated by region and chip select 3, dropped at once
    function [1:0] flash_strobes;
        input sel;
        input rd_n;
        input wr_n;
        begin
            if (sel) begin
                flash_strobes = {rd_n, wr_n}; // RULE8 RULE7
            end else begin
                flash_strobes = 2'h3; // RULE9
            end
        end
    endfunction

    always @* begin
        {o_flash_output_enable_n, o_flash_write_enable_n} =
            flash_strobes(flash_sel, i_read_strobe_n, i_write0_strobe_n); // RULE8
        // latch enables follow the transfer address, valid only inside the region
        o_flash_ale = flash_hit && i_transfer_addr[`FLASH_ALE_BIT]; // RULE10
        o_flash_cle = flash_hit && i_transfer_addr[`FLASH_CLE_BIT]; // RULE10
    end

    // boot default is safe for 16-bit nonvolatile parts at slow clock
    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_smc_byte_select_q <= `RST_BYTE_SELECT; // RULE15
            o_smc_bus16_q <= `RST_BUS_WIDTH16; // RULE15
            o_smc_cs_controlled_q <= `RST_CS_CONTROLLED; // RULE15
        end else if (i_mode_load) begin
            o_smc_byte_select_q <= i_mode_byte_select;
            o_smc_bus16_q <= i_mode_bus16;
            o_smc_cs_controlled_q <= i_mode_cs_controlled;
        end
    end

    // status: mode of the card access in progress and wait stretch length
    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_card_mode_q <= `RST_MODE_Q;
            o_card_busy_q <= 1'b0;
            o_wait_cycles_q <= `RST_WAIT_CNT;
        end else begin
            o_card_busy_q <= card_selected(card_hit, card_cs_n);
            if (card_selected(card_hit, card_cs_n)) begin
                o_card_mode_q <= i_transfer_addr[`MODE_MSB:`MODE_LSB];
                // count clears between accesses so each access reads alone
                if (!card_wait_n) begin
                    o_wait_cycles_q <= sat_inc(o_wait_cycles_q); // RULE6
                end
            end else begin
                o_wait_cycles_q <= `RST_WAIT_CNT;
            end
        end
    end
endmodule

// ===== core/pin_sync_filter.v
`timescale 1ns/1ns
module pin_sync_filter #(
    parameter RESET_LEVEL = 1'b1
) (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_pin,
    output reg o_level_q
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // first stage feeds only the second
    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s1_q <= RESET_LEVEL;
            s2_q <= RESET_LEVEL;
            s3_q <= RESET_LEVEL;
            o_level_q <= RESET_LEVEL;
        end else begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                o_level_q <= s3_q;
            end
        end
    end
endmodule

// ===== dv/card_slot_model.sv
`timescale 1ns/1ns
module card_slot_model (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_sel_n,
    output reg o_wait_n
);
    reg [3:0] cnt_q;
    reg sel_q;
    // wait only while selected; pull-up otherwise
    always @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= 4'h0;
            sel_q <= 1'b1;
            o_wait_n <= 1'b1;
        end else begin
            sel_q <= i_sel_n;
            if (sel_q && !i_sel_n) cnt_q <= 4'h6;
            else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
            o_wait_n <= cnt_q == 4'h0 || i_sel_n;
        end
    end
endmodule

// ===== dv/ext_bus_card_nand_steering_asserts.sv
`timescale 1ns/1ns
module ext_bus_card_nand_steering_asserts (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_slot0_card_assign,
    input wire i_slot1_card_assign,
    input wire i_flash_region_assign,
    input wire [31:0] i_transfer_addr,
    input wire i_smc_rnw,
    input wire i_chip_select_3_n,
    input wire i_chip_select_4_n,
    input wire i_chip_select_5_n,
    input wire i_read_strobe_n,
    input wire i_write0_strobe_n,
    input wire i_card_wait_pin_n,
    input wire i_mode_load,
    input wire i_mode_bus16,
    input wire o_external_wait_in_n,
    input wire o_chip_select_4_pin_n,
    input wire o_read_pin_n,
    input wire o_write0_pin_n,
    input wire o_write1_pin_n,
    input wire o_write3_pin_n,
    input wire [25:0] o_addr_pin,
    input wire o_flash_output_enable_n,
    input wire o_flash_write_enable_n,
    input wire o_flash_ale,
    input wire o_flash_cle,
    input wire o_smc_bus16_q
);
    wire [3:0] rg = i_transfer_addr[31:28];
    wire h0 = i_slot0_card_assign && rg == 4'h5;
    wire h1 = i_slot1_card_assign && rg == 4'h6;
    wire card = (h0 && !i_chip_select_4_n) || (h1 && !i_chip_select_5_n);
    wire mem = !i_transfer_addr[23];
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    // five samples: three sync stages plus output, and one more to sample the updated output
    sequence wait_low_seen; (!i_card_wait_pin_n) [*5]; endsequence
    sequence wait_high_seen; i_card_wait_pin_n [*5]; endsequence
    a_cs4_pin_follow: assert property (o_chip_select_4_pin_n == i_chip_select_4_n)
        else $error("cs4 pin differs from cs4");
    a_card_mem_strobes: assert property (card && mem |-> o_read_pin_n == i_read_strobe_n
        && o_write0_pin_n == i_write0_strobe_n && o_write1_pin_n && o_write3_pin_n)
        else $error("memory mode strobes wrong");
    a_card_io_strobes: assert property (card && !mem |-> o_write1_pin_n == i_read_strobe_n
        && o_write3_pin_n == i_write0_strobe_n && o_write0_pin_n)
        else $error("io mode strobes wrong");
    a_card_dir_held: assert property (card |-> o_addr_pin[25] == i_smc_rnw)
        else $error("direction pin wrong");
    a_normal_pins: assert property (!(h0 || h1) |-> o_read_pin_n == i_read_strobe_n
        && o_write0_pin_n == i_write0_strobe_n)
        else $error("normal strobes wrong");
    a_flash_strobes: assert property (i_flash_region_assign && rg == 4'h4 && !i_chip_select_3_n
        |-> {o_flash_output_enable_n, o_flash_write_enable_n}
        == {i_read_strobe_n, i_write0_strobe_n})
        else $error("flash strobes wrong");
    a_flash_off: assert property (rg != 4'h4 |-> o_flash_output_enable_n
        && o_flash_write_enable_n)
        else $error("flash strobes outside region");
    a_flash_latch: assert property (i_flash_region_assign && rg == 4'h4
        |-> o_flash_ale == i_transfer_addr[21]
        && o_flash_cle == i_transfer_addr[22])
        else $error("latch enables wrong");
    a_wait_low: assert property (wait_low_seen |-> !o_external_wait_in_n)
        else $error("wait not passed low");
    a_wait_high: assert property (wait_high_seen |-> o_external_wait_in_n)
        else $error("wait not released");
    a_mode_load: assert property (i_mode_load |=> o_smc_bus16_q == $past(i_mode_bus16))
        else $error("mode load lost");
endmodule
bind ext_bus_card_nand_steering ext_bus_card_nand_steering_asserts chk (.*);

// ===== dv/ext_bus_card_nand_steering_tb.sv
`timescale 1ns/1ns
module ext_bus_card_nand_steering_tb;
    reg i_sys_clk = 0, i_rstn = 0, i_slot0_card_assign = 0, i_slot1_card_assign = 0;
    reg i_flash_region_assign = 0, i_sdram_region_assign = 0, i_smc_rnw = 1;
    reg [31:0] i_transfer_addr = 0;
    reg [25:0] i_smc_addr = 0;
    reg i_chip_select_3_n = 1, i_chip_select_4_n = 1, i_chip_select_5_n = 1;
    reg i_read_strobe_n = 1, i_write0_strobe_n = 1, i_write1_byte1_strobe_n = 1;
    reg i_write3_byte3_strobe_n = 1, i_byte0_select_n = 0, i_card0_bus16 = 1;
    reg i_card1_bus16 = 1, i_mode_load = 0, i_mode_byte_select = 1, i_mode_bus16 = 1;
    reg i_mode_cs_controlled = 1;
    wire i_card_wait_pin_n, o_external_wait_in_n, o_chip_select_4_pin_n;
    wire o_chip_select_5_pin_n, o_read_pin_n, o_write0_pin_n, o_write1_pin_n;
    wire o_write3_pin_n, o_card_enable_low_n, o_card_enable_high_n, o_flash_ale;
    wire o_flash_output_enable_n, o_flash_write_enable_n, o_flash_cle, o_sdram_cs1_routed;
    wire o_smc_byte_select_q, o_smc_bus16_q, o_smc_cs_controlled_q, o_card_busy_q;
    wire [25:0] o_addr_pin;
    wire [2:0] o_card_mode_q;
    wire [7:0] o_wait_cycles_q;
    integer n_tests = 0, err_total = 0, m, k;
    reg [1:0] e;
    ext_bus_card_nand_steering uut (.*);
    card_slot_model slot (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
        .i_sel_n(o_chip_select_4_pin_n), .o_wait_n(i_card_wait_pin_n));
    always #25 i_sys_clk = ~i_sys_clk;
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("Error at %0t: got %0h expected %0h", $time, got, exp);
            end
        end
    endtask
    // smc address inverted so a card write's direction bit differs from plain A25
    task acc(input [31:0] a, input [2:0] cs_n, input rd_n, input wr_n);
        begin
            @(posedge i_sys_clk);
            i_transfer_addr <= a;
            i_smc_addr <= ~a[25:0];
            {i_chip_select_5_n, i_chip_select_4_n, i_chip_select_3_n} <= cs_n;
            i_read_strobe_n <= rd_n;
            i_write0_strobe_n <= wr_n;
            i_smc_rnw <= wr_n;
            @(negedge i_sys_clk);
        end
    endtask
    task asg(input [3:0] v);
        begin
            @(posedge i_sys_clk);
            {i_slot0_card_assign, i_slot1_card_assign, i_flash_region_assign,
                i_sdram_region_assign} <= v;
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d errors %0d", n_tests, err_total);
            if (err_total == 0 && n_tests > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task wait_ext(input lvl);
        begin
            for (k = 0; k < 12 && o_external_wait_in_n !== lvl; k = k + 1) @(negedge i_sys_clk);
            if (k == 12) begin
                err_total = err_total + 1;
                $display("Error at %0t: wait timeout", $time);
                finish_test;
            end
        end
    endtask
    initial begin
        repeat (6) @(posedge i_sys_clk);
        i_rstn <= 1;
        @(negedge i_sys_clk);
        chk({o_smc_byte_select_q, o_smc_bus16_q, o_smc_cs_controlled_q}, 3'h7);
        chk({o_card_mode_q, o_card_busy_q, o_wait_cycles_q, o_external_wait_in_n}, 13'h0001);
        asg(4'h8);
        for (m = 0; m < 8; m = m + 1) begin
            acc(32'h50000000 | (m << 21), 3'h5, 1'b0, 1'b1);
            e = m < 4 ? 2'h1 : m < 6 ? 2'h2 : 2'h0;
            chk({o_read_pin_n, o_write1_pin_n, o_addr_pin[25]}, {e, 1'b1});
            chk({o_card_enable_low_n, o_card_enable_high_n}, m == 7 ? 2'h2 : 2'h1);
            acc(32'h50000000 | (m << 21), 3'h5, 1'b1, 1'b0);
            e = m < 4 ? 2'h1 : 2'h2;
            chk({o_write0_pin_n, o_write3_pin_n, o_addr_pin[25]}, {e, 1'b0});
        end
        acc(32'h50000000, 3'h7, 1'b0, 1'b1);
        chk({o_card_enable_low_n, o_card_enable_high_n, o_chip_select_4_pin_n}, 3'h7);
        asg(4'h0);
        acc(32'h50800000, 3'h5, 1'b0, 1'b1);
        chk({o_read_pin_n, o_write1_pin_n, o_addr_pin[25]}, 3'h3);
        asg(4'h4);
        acc(32'h60800000, 3'h3, 1'b0, 1'b1);
        chk({o_read_pin_n, o_write1_pin_n}, 2'h2);
        chk({o_chip_select_5_pin_n, o_chip_select_4_pin_n, o_card_enable_low_n,
            o_card_enable_high_n}, 4'h5);
        acc(32'h70800000, 3'h3, 1'b0, 1'b1);
        chk({o_read_pin_n, o_write1_pin_n}, 2'h1);
        chk(o_addr_pin, 26'h37FFFFF);
        asg(4'h7);
        acc(32'h40600000, 3'h6, 1'b0, 1'b1);
        chk({o_flash_output_enable_n, o_flash_write_enable_n, o_flash_ale, o_flash_cle},
            4'h7);
        chk(o_sdram_cs1_routed, 1'b1);
        acc(32'h40200000, 3'h6, 1'b1, 1'b0);
        chk({o_flash_output_enable_n, o_flash_write_enable_n, o_flash_ale, o_flash_cle},
            4'hA);
        acc(32'h4FFFFFFF, 3'h6, 1'b0, 1'b1);
        chk({o_flash_output_enable_n, o_flash_ale, o_flash_cle}, 3'h3);
        acc(32'h50600000, 3'h6, 1'b0, 1'b1);
        chk({o_flash_output_enable_n, o_flash_write_enable_n}, 2'h3);
        asg(4'hF);
        acc(32'h50400000, 3'h5, 1'b0, 1'b1);
        wait_ext(1'b0);
        wait_ext(1'b1);
        repeat (2) @(negedge i_sys_clk);
        chk(o_wait_cycles_q, 8'h06);
        @(posedge i_sys_clk);
        {i_mode_load, i_mode_byte_select, i_mode_bus16, i_mode_cs_controlled} <= 4'h9;
        @(posedge i_sys_clk);
        i_mode_load <= 0;
        @(negedge i_sys_clk);
        chk({o_smc_byte_select_q, o_smc_bus16_q, o_smc_cs_controlled_q}, 3'h1);
        repeat (2) @(posedge i_sys_clk);
        i_rstn <= 0;
        @(posedge i_sys_clk);
        i_rstn <= 1;
        @(negedge i_sys_clk);
        chk({o_smc_byte_select_q, o_smc_bus16_q, o_smc_cs_controlled_q}, 3'h7);
        chk({o_card_mode_q, o_card_busy_q, o_wait_cycles_q}, 12'h000);
        @(negedge i_sys_clk);
        chk({o_card_mode_q, o_card_busy_q}, 4'h5);
        finish_test;
    end
endmodule
